// *** design/ncs_map.svh ***
// Constants of the nibble core: register port offsets, reset values,
// page numbers and interrupt vector offsets.
// Included by the core and the return stack; holds definitions only.
`ifndef NCS_MAP_SVH
`define NCS_MAP_SVH

`define NCS_PC_W          12
`define NCS_STACK_DEPTH   8
`define NCS_SRC_N         5
`define NCS_OFF_CTRL_LOW  4'h0
`define NCS_OFF_CTRL_HIGH 4'h1
`define NCS_OFF_REQ       4'h2
`define NCS_OFF_STATUS    4'h3
`define NCS_RST_PC        12'h000
`define NCS_RST_CTRL      4'h0
`define NCS_PAGE1         5'h01
`define NCS_PAGE2         5'h02
`define NCS_VEC_EXT       7'h00
`define NCS_VEC_TMR1      7'h04
`define NCS_VEC_TMR2      7'h06
`define NCS_VEC_ADC       7'h0C
`define NCS_VEC_SIO       7'h0E

`endif

// *** design/ncs_pkg.sv ***
// Types of the nibble core: the decoded operation set.
// Used by the core and by whatever decodes instruction words for it.
package ncs_pkg;

    typedef enum logic [5:0] {
        op_nop, op_load_imm, op_add_imm, op_add_mem, op_add_mem_with_carry,
        op_and_mem, op_or_mem, op_cmp_imm, op_rotate_right_instr,
        op_set_carry_instr, op_clear_carry_instr, op_load_mem, op_store_mem,
        op_load_b, op_e_from_ba, op_ba_from_e, op_load_d,
        op_set_upper_table_instr, op_clear_upper_table_instr,
        op_table_reference_instr, op_indirect_branch_instr,
        op_indirect_page2_call_instr, op_page2_call_instr, op_call, op_branch,
        op_return, op_return_from_irq_instr, op_copy_stack_level_instr,
        op_enable_irq_instr, op_disable_irq_instr, op_ram_bit_set_instr,
        op_ram_bit_reset_instr, op_ram_bit_test_instr, op_port_bit_set_instr,
        op_port_bit_reset_instr, op_port_bit_test_instr, op_load_dp,
        op_irq_skip_test, op_ctrl_low_from_a, op_ctrl_high_from_a,
        op_a_from_ctrl_low, op_a_from_ctrl_high
    } ncs_op_t;

    typedef enum logic {st_run, st_table} ncs_state_t;

endpackage

// *** design/ncs_stack.sv ***
// Eight-deep return address stack with a wrapping level pointer.
// Assumes push and pop never come in the same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "ncs_map.svh"

module ncs_stack (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Push and pop
    input  wire logic        push,
    input  wire logic        pop,
    input  wire logic [11:0] push_addr,
    output logic      [11:0] top_addr,
    output logic      [2:0]  level
);
    logic [11:0] slot [`NCS_STACK_DEPTH];

    // Wraps modulo eight: a ninth push overwrites the oldest entry
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            level <= 3'h0;
        end else if (push) begin
            level <= level + 3'h1;
        end else if (pop) begin
            level <= level - 3'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            slot[level] <= push_addr;
        end
    end

    assign top_addr = slot[level - 3'h1];
endmodule
`default_nettype wire

// *** design/ncs_core.sv ***
// Architectural state and sequencing of a 4-bit core: ALU, accumulator,
// carry, B/E/D, return stack, interrupt context, skip, PC, RAM pointer.
// Assumes a decoder presents one operation per op_valid cycle and an
// asynchronous program ROM answering rom_addr in the same cycle.
//
// Summary of operation
// - ALU works on 4-bit values: add, compare, AND, OR, bit operations.
// - Add-with-carry sets carry on carry out and never clears it; plain adds leave carry alone.
// - Rotate right moves A bit 0 into carry; set/clear carry force it.
// - E is copied from and copied back to the byte formed by B high and A low.
// - E and D are not reset; software initialises them.
// - D with A forms the 7-bit in-page ROM address for indirect ops.
// - Table reference with upper flag loads D from ROM bits 9..8.
// - Eight return slots; interrupt, call and table reference push PC.
// - A 3-bit level pointer tracks nesting and can be copied to A.
// - One context slot saves pointer, carry, skip, A and B on interrupt.
// - Skip flag is saved on interrupt entry and restored on return.
// - PC advances by instruction length unless a branch loads it.
// - PC has page and 7-bit offset; offset 127 rolls to next page.
// - RAM pointer is Z, X, Y; Y also picks the port D bit.
// - Program words are 10 bits, 128 per page, 4096 in 32 pages.
// - Page 1 holds interrupt vectors; interrupt loads the source vector.
// - One-word page-2 call reaches page 2 from anywhere.
// - Table reference returns the low eight bits of any ROM word.
// - RAM is 256 nibbles with bit set, reset and test everywhere.
// - Interrupt needs request flag, source enable and global enable.
// - Enable/disable ops set/clear global enable; any interrupt clears it.
// - Source enable bits live in the two interrupt control registers.
// - Enable 1 allows interrupt, disables skip test; 0 the reverse.
// - Request flags set always, hold, clear on interrupt or skip.
// - Priority external, timer 1, timer 2, A/D, serial; vectors 0,4,6,C,E.
// - Enable takes effect only after the next instruction completes.
`timescale 1ns/1ps
`default_nettype none
`include "ncs_map.svh"

module ncs_core
    import ncs_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Decoded operation
    input  wire logic        op_valid,
    input  wire ncs_op_t     op_code,
    input  wire logic [11:0] op_arg,
    input  wire logic        op_two_word,
    output logic             op_ready,
    // Program ROM
    output logic      [11:0] pc,
    output logic      [11:0] rom_addr,
    input  wire logic [9:0]  rom_data,
    // Interrupt sources: ext, timer 1, timer 2, A/D, serial
    input  wire logic [4:0]  irq_event,
    output logic             irq_taken,
    // Port D
    input  wire logic [7:0]  port_d_in,
    output logic      [7:0]  port_d_out,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Observed state
    output logic      [3:0]  acc,
    output logic             carry_flag
);
    ncs_state_t  state;
    logic [3:0]  reg_b, ctrl_low, ctrl_high, dp_x, dp_y;
    logic [7:0]  reg_e;
    logic [2:0]  reg_d, stack_level;
    logic [1:0]  dp_z;
    logic        skip_flag, upper_table_enable_flag, global_irq_enable, ei_hold;
    logic [4:0]  req;
    logic [24:0] ctx;
    logic [3:0]  ram [256];
    logic [11:0] stack_top, next_pc, push_addr;
    logic [4:0]  en, pend, grant;
    logic [6:0]  vec;
    logic [4:0]  sum;
    logic [3:0]  mem_rd, add_op, ram_wd;
    logic [7:0]  ram_idx;
    logic        go, irq_go, exec, skip_hit, push, pop, ram_we, ram_hit, table_done;

    assign ram_idx = {dp_x, dp_y};
    assign ram_hit = (dp_z == 2'h0);
    assign mem_rd  = ram_hit ? ram[ram_idx] : 4'h0;
    assign en      = {ctrl_high[3], ctrl_high[2], ctrl_low[3], ctrl_low[2], ctrl_low[0]};
    assign pend    = req & en;
    assign go      = op_valid & op_ready;
    assign irq_go  = go & global_irq_enable & ~ei_hold & (|pend);
    assign exec    = go & ~irq_go & ~skip_flag;
    assign table_done = (state == st_table);
    assign next_pc = pc + (op_two_word ? 12'h002 : 12'h001);

    // Fixed priority, lowest index wins
    always_comb begin
        grant = 5'h00;
        vec   = `NCS_VEC_SIO;
        if (pend[0]) begin
            grant = 5'h01;
            vec   = `NCS_VEC_EXT;
        end else if (pend[1]) begin
            grant = 5'h02;
            vec   = `NCS_VEC_TMR1;
        end else if (pend[2]) begin
            grant = 5'h04;
            vec   = `NCS_VEC_TMR2;
        end else if (pend[3]) begin
            grant = 5'h08;
            vec   = `NCS_VEC_ADC;
        end else if (pend[4]) begin
            grant = 5'h10;
        end
    end

    always_comb begin
        add_op = (op_code == op_add_imm) ? op_arg[3:0] : mem_rd;
        sum    = {1'b0, acc} + {1'b0, add_op}
                 + {4'h0, (op_code == op_add_mem_with_carry) & carry_flag};
        case (op_code)
            op_cmp_imm:             skip_hit = (acc == op_arg[3:0]);
            op_ram_bit_test_instr:  skip_hit = ~mem_rd[op_arg[1:0]];
            op_port_bit_test_instr: skip_hit = ~port_d_in[dp_y[2:0]];
            op_irq_skip_test:       skip_hit = req[op_arg[2:0]] & ~en[op_arg[2:0]];
            default:                skip_hit = 1'b0;
        endcase
        ram_wd = acc;
        ram_we = 1'b0;
        case (op_code)
            op_store_mem: ram_we = exec & ram_hit;
            op_ram_bit_set_instr: begin
                ram_we = exec & ram_hit;
                ram_wd = mem_rd | (4'h1 << op_arg[1:0]);
            end
            op_ram_bit_reset_instr: begin
                ram_we = exec & ram_hit;
                ram_wd = mem_rd & ~(4'h1 << op_arg[1:0]);
            end
            default: ram_we = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (ram_we) begin
            ram[ram_idx] <= ram_wd;
        end
    end

    // Return stack traffic
    always_comb begin
        push      = irq_go;
        push_addr = pc;
        pop       = table_done;
        if (exec) begin
            case (op_code)
                op_call, op_page2_call_instr, op_indirect_page2_call_instr,
                op_table_reference_instr: begin
                    push      = 1'b1;
                    push_addr = next_pc;
                end
                op_return, op_return_from_irq_instr: pop = 1'b1;
                default: push = 1'b0;
            endcase
        end
    end

    ncs_stack u_stack (
        .core_clk  (core_clk),
        .rst       (rst),
        .push      (push),
        .pop       (pop),
        .push_addr (push_addr),
        .top_addr  (stack_top),
        .level     (stack_level)
    );

    // Sequencing: PC, table wait state, ROM table address
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pc        <= `NCS_RST_PC;
            state     <= st_run;
            op_ready  <= 1'b1;
            rom_addr  <= `NCS_RST_PC;
            irq_taken <= 1'b0;
        end else begin
            irq_taken <= irq_go;
            if (table_done) begin
                state    <= st_run;
                op_ready <= 1'b1;
                pc       <= stack_top;
            end else if (irq_go) begin
                pc <= {`NCS_PAGE1, vec};
            end else if (go && !exec) begin
                pc <= next_pc;
            end else if (exec) begin
                case (op_code)
                    op_branch, op_call: pc <= op_arg;
                    op_page2_call_instr: pc <= {`NCS_PAGE2, op_arg[6:0]};
                    op_indirect_branch_instr, op_indirect_page2_call_instr:
                        pc <= {op_arg[4:0], reg_d, acc};
                    op_return, op_return_from_irq_instr: pc <= stack_top;
                    op_table_reference_instr: begin
                        rom_addr <= {op_arg[4:0], reg_d, acc};
                        state    <= st_table;
                        op_ready <= 1'b0;
                    end
                    default: pc <= next_pc;
                endcase
            end
        end
    end

    // Accumulator, carry, upper-table flag and skip
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            acc                     <= 4'h0;
            reg_b                   <= 4'h0;
            carry_flag              <= 1'b0;
            upper_table_enable_flag <= 1'b0;
            skip_flag               <= 1'b0;
        end else if (table_done) begin
            {reg_b, acc} <= rom_data[7:0];
        end else if (go && !exec) begin
            // Also on interrupt entry: the saved copy keeps a pending skip
            skip_flag <= 1'b0;
        end else if (exec) begin
            skip_flag <= skip_hit;
            case (op_code)
                op_load_imm:  acc <= op_arg[3:0];
                op_load_mem:  acc <= mem_rd;
                op_load_b:    reg_b <= op_arg[3:0];
                op_add_imm, op_add_mem: acc <= sum[3:0];
                op_add_mem_with_carry: begin
                    acc <= sum[3:0];
                    if (sum[4]) begin
                        carry_flag <= 1'b1;
                    end
                end
                op_and_mem: acc <= acc & mem_rd;
                op_or_mem:  acc <= acc | mem_rd;
                op_rotate_right_instr: begin
                    acc        <= {carry_flag, acc[3:1]};
                    carry_flag <= acc[0];
                end
                op_set_carry_instr:   carry_flag <= 1'b1;
                op_clear_carry_instr: carry_flag <= 1'b0;
                op_ba_from_e: {reg_b, acc} <= reg_e;
                op_set_upper_table_instr:   upper_table_enable_flag <= 1'b1;
                op_clear_upper_table_instr: upper_table_enable_flag <= 1'b0;
                op_copy_stack_level_instr:  acc <= {1'b0, stack_level};
                op_a_from_ctrl_low:  acc <= ctrl_low;
                op_a_from_ctrl_high: acc <= ctrl_high;
                op_return_from_irq_instr: begin
                    {carry_flag, skip_flag, acc, reg_b} <= ctx[9:0];
                end
                default: acc <= acc;
            endcase
        end
    end

    // E, D and the context slot are left unreset on purpose
    always_ff @(posedge core_clk) begin
        if (exec && op_code == op_e_from_ba) begin
            reg_e <= {reg_b, acc};
        end
        if (exec && op_code == op_load_d) begin
            reg_d <= op_arg[2:0];
        end else if (table_done && upper_table_enable_flag) begin
            reg_d <= {1'b0, rom_data[9:8]};
        end
        if (irq_go) begin
            ctx <= {dp_z, dp_x, dp_y, 5'h00, carry_flag, skip_flag,
                    acc, reg_b};
        end
    end

    // RAM pointer and port D
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dp_z       <= 2'h0;
            dp_x       <= 4'h0;
            dp_y       <= 4'h0;
            port_d_out <= 8'h00;
        end else if (exec) begin
            case (op_code)
                op_load_dp: {dp_z, dp_x, dp_y} <= op_arg[9:0];
                op_port_bit_set_instr:   port_d_out[dp_y[2:0]] <= 1'b1;
                op_port_bit_reset_instr: port_d_out[dp_y[2:0]] <= 1'b0;
                op_return_from_irq_instr: {dp_z, dp_x, dp_y} <= ctx[24:15];
                default: dp_y <= dp_y;
            endcase
        end
    end

    // Global enable, enable delay and request flags; a new event beats a clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            global_irq_enable <= 1'b0;
            ei_hold           <= 1'b0;
            req               <= 5'h00;
        end else begin
            req <= (req & ~((irq_go ? grant : 5'h00)
                   | ((exec && op_code == op_irq_skip_test && skip_hit)
                      ? (5'h01 << op_arg[2:0]) : 5'h00))) | irq_event;
            if (irq_go) begin
                global_irq_enable <= 1'b0;
            end else if (exec && op_code == op_enable_irq_instr) begin
                global_irq_enable <= 1'b1;
                ei_hold           <= 1'b1;
            end else if (exec && op_code == op_disable_irq_instr) begin
                global_irq_enable <= 1'b0;
                ei_hold           <= 1'b0;
            end else if (go) begin
                ei_hold <= 1'b0;
            end
        end
    end

    // Control registers, written by software port or from A
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_low  <= `NCS_RST_CTRL;
            ctrl_high <= `NCS_RST_CTRL;
            reg_rdata <= 8'h00;
        end else begin
            if (reg_wr && reg_addr == `NCS_OFF_CTRL_LOW) begin
                ctrl_low <= reg_wdata[3:0];
            end else if (exec && op_code == op_ctrl_low_from_a) begin
                ctrl_low <= acc;
            end
            if (reg_wr && reg_addr == `NCS_OFF_CTRL_HIGH) begin
                ctrl_high <= reg_wdata[3:0];
            end else if (exec && op_code == op_ctrl_high_from_a) begin
                ctrl_high <= acc;
            end
            if (reg_rd) begin
                case (reg_addr)
                    `NCS_OFF_CTRL_LOW:  reg_rdata <= {4'h0, ctrl_low};
                    `NCS_OFF_CTRL_HIGH: reg_rdata <= {4'h0, ctrl_high};
                    `NCS_OFF_REQ:       reg_rdata <= {3'h0, req};
                    `NCS_OFF_STATUS:    reg_rdata <= {global_irq_enable,
                        upper_table_enable_flag, carry_flag, skip_flag, 1'b0, stack_level};
                    default:            reg_rdata <= 8'h00;
                endcase
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    a_rar_carry: assert property (@(posedge core_clk) disable iff (rst)
        exec && op_code == op_rotate_right_instr |=> carry_flag == $past(acc[0]))
        else $error("rotate did not move bit 0 to carry");
    a_carry_force: assert property (@(posedge core_clk) disable iff (rst)
        exec && op_code == op_clear_carry_instr |=> !carry_flag)
        else $error("clear carry failed");
    a_add_keeps_cy: assert property (@(posedge core_clk) disable iff (rst)
        exec && op_code == op_add_imm |=> $stable(carry_flag))
        else $error("plain add changed carry");
    a_irq_gating: assert property (@(posedge core_clk) disable iff (rst)
        irq_go |-> global_irq_enable && !ei_hold && (req & en) != 5'h00)
        else $error("interrupt taken without all enables");
    a_irq_entry: assert property (@(posedge core_clk) disable iff (rst)
        irq_go |=> irq_taken && !global_irq_enable && pc[11:7] == `NCS_PAGE1)
        else $error("interrupt entry state wrong");
    a_ei_delay: assert property (@(posedge core_clk) disable iff (rst)
        exec && op_code == op_enable_irq_instr |=> !irq_go)
        else $error("interrupt taken right after enable");
    a_call_push: assert property (@(posedge core_clk) disable iff (rst)
        exec && op_code == op_call |=> stack_level == $past(stack_level) + 3'h1)
        else $error("call did not push");
    a_table_ret: assert property (@(posedge core_clk) disable iff (rst)
        exec && op_code == op_table_reference_instr |=> !op_ready ##1
        (op_ready && pc == $past(pc, 2) + (12'h001 << $past(op_two_word, 2))))
        else $error("table reference sequence wrong");
    a_upt_off_d: assert property (@(posedge core_clk) disable iff (rst)
        table_done && !upper_table_enable_flag |=> reg_d == $past(reg_d))
        else $error("D changed with upper flag clear");
    c_irq: cover property (@(posedge core_clk) disable iff (rst) irq_go);
    c_table: cover property (@(posedge core_clk) disable iff (rst) table_done);
    c_skip: cover property (@(posedge core_clk) disable iff (rst) go && skip_flag);
    c_wrap: cover property (@(posedge core_clk) disable iff (rst)
        push && stack_level == 3'h7);
endmodule
`default_nettype wire

// *** tb/ncs_rom_model.sv ***
// Program ROM model for the nibble core: 10-bit words, combinational read.
// Assumes the core samples rom_data in the cycle after it sets rom_addr.
`timescale 1ns/1ps
`default_nettype none
module ncs_rom_model (
    // Table read
    input  wire logic [11:0] rom_addr,
    output logic      [9:0]  rom_data
);
    // Each word follows address bits 7..0, so a wrong low address byte shows up in the data
    assign rom_data = {rom_addr[1:0] ^ 2'h1, rom_addr[7:0] ^ 8'hA5};
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the nibble core, with the ROM model on its far side.
// Assumes the core's register offsets and reset values from ncs_map.svh.
`timescale 1ns/1ps
`default_nettype none
`include "ncs_map.svh"
module tb
    import ncs_pkg::*;
;
    logic        core_clk;
    logic        rst;
    logic        op_valid;
    ncs_op_t     op_code;
    logic [11:0] op_arg;
    logic        op_two_word;
    logic        op_ready;
    logic [11:0] pc;
    logic [11:0] rom_addr;
    logic [9:0]  rom_data;
    logic [4:0]  irq_event;
    logic        irq_taken;
    logic [7:0]  port_d_in;
    logic [7:0]  port_d_out;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic [3:0]  acc;
    logic        carry_flag;
    logic        seen_irq;
    logic        seen_rdy;
    logic [11:0] seen_rom;
    logic [11:0] pc0;
    logic [7:0]  rd;
    logic [3:0]  r;
    logic [9:0]  w;
    int          n_errors = 0;
    int          comparisons = 0;

    ncs_core u_ncs_core (
        .core_clk, .rst, .op_valid, .op_code, .op_arg, .op_two_word, .op_ready, .pc,
        .rom_addr, .rom_data, .irq_event, .irq_taken, .port_d_in, .port_d_out,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .acc, .carry_flag
    );
    ncs_rom_model u_ncs_rom_model (.rom_addr, .rom_data);

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    function automatic logic [9:0] rom_word(logic [11:0] a);
        return {a[1:0] ^ 2'h1, a[7:0] ^ 8'hA5};
    endfunction

    task automatic chk(string nm, logic [11:0] exp, logic [11:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One operation, then one idle cycle so the table dead cycle is always met
    task automatic do_op(ncs_op_t c, logic [11:0] a = 12'h000, logic tw = 1'b0);
        op_code <= c;
        op_arg <= a;
        op_two_word <= tw;
        op_valid <= 1'b1;
        @(posedge core_clk);
        op_valid <= 1'b0;
        #1;
        seen_irq = irq_taken;
        seen_rdy = op_ready;
        seen_rom = rom_addr;
        @(posedge core_clk);
        #1;
    endtask

    task automatic reg_write(logic [3:0] a, logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic reg_read(logic [3:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        rd = reg_rdata;
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Whole run needs about 110 cycles
    initial begin
        repeat (3000) @(posedge core_clk);
        n_errors++;
        $display("ERROR watchdog expired");
        finish_test();
    end

    initial begin
        rst = 1'b1;
        op_valid = 1'b0;
        op_code = op_nop;
        op_arg = 12'h000;
        op_two_word = 1'b0;
        irq_event = 5'h00;
        port_d_in = 8'h00;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        void'($urandom(59));
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        port_d_in <= 8'($urandom);
        @(posedge core_clk);
        #1;
        chk("pc", `NCS_RST_PC, pc);
        reg_read(`NCS_OFF_STATUS);
        chk("status", 12'h000, {4'h0, rd});
        reg_read(4'hF);
        chk("unmapped", 12'h000, {4'h0, rd});
        $display("test reset done");
        do_op(op_clear_carry_instr);
        do_op(op_load_dp, 12'h000);
        do_op(op_load_imm, 12'h009);
        do_op(op_store_mem);
        do_op(op_load_imm, 12'h008);
        do_op(op_add_mem_with_carry);
        chk("amc", 12'h011, {7'h00, carry_flag, acc});
        do_op(op_add_mem);
        r = 4'($urandom);
        do_op(op_add_imm, {8'h00, r});
        chk("add", {7'h00, 1'b1, 4'(4'hA + r)}, {7'h00, carry_flag, acc});
        do_op(op_load_imm, 12'h005);
        do_op(op_cmp_imm, 12'h005);
        do_op(op_load_imm, 12'h007);
        chk("skip", 12'h005, {8'h00, acc});
        do_op(op_ram_bit_reset_instr, 12'h003);
        do_op(op_load_mem);
        chk("bit reset", 12'h001, {8'h00, acc});
        do_op(op_e_from_ba);
        do_op(op_load_imm, 12'h000);
        do_op(op_ba_from_e);
        chk("e swap", 12'h001, {8'h00, acc});
        r = 4'($urandom);
        do_op(op_load_imm, {8'h00, r});
        do_op(op_rotate_right_instr);
        chk("rotate carry", {11'h000, r[0]}, {11'h000, carry_flag});
        do_op(op_set_carry_instr);
        chk("set carry", 12'h001, {11'h000, carry_flag});
        r = 4'($urandom_range(7));
        do_op(op_load_dp, {8'h00, r});
        do_op(op_port_bit_set_instr);
        chk("port d", {4'h0, 8'h01 << r}, {4'h0, port_d_out});
        $display("test alu done");
        do_op(op_branch, 12'h07E);
        do_op(op_nop, 12'h000, 1'b1);
        chk("pc wrap", 12'h080, pc);
        do_op(op_load_d, 12'h003);
        do_op(op_set_upper_table_instr);
        do_op(op_load_imm, 12'h005);
        do_op(op_table_reference_instr, 12'h002);
        w = rom_word({5'h02, 3'h3, 4'h5});
        chk("table addr", {5'h02, 3'h3, 4'h5}, seen_rom);
        chk("table ready", 12'h000, {11'h000, seen_rdy});
        chk("table data", {8'h00, w[3:0]}, {8'h00, acc});
        chk("table pc", 12'h084, pc);
        do_op(op_clear_upper_table_instr);
        do_op(op_load_imm, 12'h006);
        do_op(op_table_reference_instr, 12'h002);
        chk("upper d", {5'h02, 1'b0, w[9:8], 4'h6}, seen_rom);
        do_op(op_load_imm, 12'h006);
        do_op(op_table_reference_instr, 12'h002);
        chk("d kept", {5'h02, 1'b0, w[9:8], 4'h6}, seen_rom);
        $display("test table done");
        reg_write(`NCS_OFF_CTRL_LOW, 8'h04);
        irq_event <= 5'h03;
        @(posedge core_clk);
        irq_event <= 5'h00;
        #1;
        do_op(op_enable_irq_instr);
        do_op(op_nop);
        chk("enable delay", 12'h000, {11'h000, seen_irq});
        pc0 = pc;
        do_op(op_nop);
        chk("vector", {`NCS_PAGE1, `NCS_VEC_TMR1}, pc);
        chk("irq pulse", 12'h001, {11'h000, seen_irq});
        reg_read(`NCS_OFF_STATUS);
        chk("enable clear", 12'h001, {4'h0, rd & 8'h87});
        do_op(op_return_from_irq_instr);
        chk("irq return", pc0, pc);
        $display("test interrupt done");
        repeat (9) do_op(op_call, 12'h200);
        do_op(op_copy_stack_level_instr);
        chk("level wrap", 12'h001, {8'h00, acc});
        do_op(op_return);
        chk("return", 12'h201, pc);
        $display("test stack done");
        finish_test();
    end
endmodule
`default_nettype wire
